// ===== verilog/frs_defs.vh
/*
  Constants of the frequency reference selector: register indices, reset
  values, source codes, terminal function codes and timing counts.
  Assumes a 200 MHz system clock and a word-indexed register port.
*/
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH
// Register indices (word addresses).
`define FRS_A_SRC       5'h00
`define FRS_A_FULL      5'h01
`define FRS_A_FMAX      5'h02
`define FRS_A_FILT      5'h03
`define FRS_A_X1        5'h04
`define FRS_A_Y1        5'h05
`define FRS_A_X2        5'h06
`define FRS_A_Y2        5'h07
`define FRS_A_INV       5'h08
`define FRS_A_QUANT     5'h09
`define FRS_A_UNIT      5'h0a
`define FRS_A_SERIAL    5'h0b
`define FRS_A_CHECK     5'h0c
`define FRS_A_STEP1     5'h0d
`define FRS_A_TERM1     5'h14
`define FRS_N_RW        5'h1b
`define FRS_A_MON       5'h1b
`define FRS_A_FREQ      5'h1c
`define FRS_A_STAT      5'h1d
// Reset values; frequencies in 0.01 Hz, rates in 0.01 kHz, percent in 0.01%.
`define FRS_R_FULL      16'h1770
`define FRS_R_FMAX      16'h1770
`define FRS_R_FILT      16'h000a
`define FRS_R_X1        16'h0000
`define FRS_R_Y1        16'h0000
`define FRS_R_X2        16'h0c80
`define FRS_R_Y2        16'h2710
`define FRS_R_QUANT     16'h0004
`define FRS_R_CHECK     16'h0001
// Limits.
`define FRS_PCT_FULL    32'h0000_2710
`define FRS_MON_MAX     16'h1388
// Frequency source codes.
`define FRS_SRC_V1      4'h2
`define FRS_SRC_V2      4'h4
`define FRS_SRC_I2      4'h5
`define FRS_SRC_SERIAL  4'h6
`define FRS_SRC_PULSE   4'hc
// Terminal function codes.
`define FRS_FN_FWD      6'h01
`define FRS_FN_REV      6'h02
`define FRS_FN_SPD_L    6'h07
`define FRS_FN_SPD_M    6'h08
`define FRS_FN_SPD_H    6'h09
`define FRS_FN_HOLD     6'h15
// Timing: one millisecond tick and the pulse gate interval.
`define FRS_CLK_NS      5
`define FRS_MS_NS       1000000
`define FRS_MS_CYCLES   (`FRS_MS_NS / `FRS_CLK_NS)
`define FRS_GATE_MS     100
`endif

// ===== verilog/frs_lpf.v
/*
  First-order low-pass filter stepped once per millisecond tick.
  Assumes the time constant is given in whole milliseconds.
*/
`timescale 1ns/10ps
module frs_lpf #(
  parameter DW = 16
) (
  input  wire          i_clk_sys,
  input  wire          i_rstn,
  input  wire          i_tick,
  input  wire [DW-1:0] i_x,
  input  wire [15:0]   i_tc,
  output wire [DW-1:0] o_y
);
  reg  signed [DW+9:0] acc_q;
  reg  signed [DW+9:0] acc_d;
  reg  signed [DW+9:0] err;

  // Each tick moves the output by error over time constant, so a step
  // reaches about 63% after one time constant; zero passes straight.
  always @* begin
    err   = $signed({2'b00, i_x, 8'h00}) - acc_q;
    acc_d = acc_q;
    if (i_tick) begin
      if (i_tc == 16'h0000)
        acc_d = $signed({2'b00, i_x, 8'h00});
      else
        acc_d = acc_q + err / $signed({{(DW-6){1'b0}}, i_tc});
    end
  end

  // Accumulator holds eight fraction bits.
  always @(posedge i_clk_sys) begin
    if (!i_rstn)
      acc_q <= {(DW+10){1'b0}};
    else
      acc_q <= acc_d;
  end

  assign o_y = acc_q[DW+7:8];
endmodule

// ===== verilog/frs_top.v
/*
  Frequency reference selector: pulse measurement, filtering, scaling,
  quantizing, source selection, hold, multi-step speeds and speed display.
  Assumes inputs synchronous to i_clk_sys except the pulse pin, which is
  synchronised here, and a register port answering reads one cycle later.
*/
`timescale 1ns/10ps
`include "frs_defs.vh"
module frs_top #(
  parameter DW        = 16,
  parameter NTERM     = 7,
  parameter MS_CYCLES = `FRS_MS_CYCLES,
  parameter GATE_MS   = `FRS_GATE_MS,
  parameter POLES     = 4
) (
  input  wire          i_clk_sys,
  input  wire          i_rstn,
  input  wire [4:0]    i_addr,
  input  wire [DW-1:0] i_wdata,
  input  wire          i_wr,
  input  wire          i_rd,
  output reg  [DW-1:0] o_rdata,
  input  wire          i_pulse_in_pin,
  input  wire [NTERM-1:0] i_terminals,
  input  wire [DW-1:0] i_ext_freq,
  output reg  [DW-1:0] o_freq_cmd,
  output reg           o_dir_rev,
  output reg           o_forward_run_cmd,
  output reg  [2:0]    o_step,
  output reg  [DW-1:0] o_speed_disp
);
  // Step settling states, one-hot: idle keeps the applied step, wait
  // counts millisecond ticks down after a select input has moved.
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  // Reset value of each writable register.
  function [DW-1:0] rst_val;
    input [4:0] idx;
    begin
      case (idx)
        `FRS_A_FULL:  rst_val = `FRS_R_FULL;
        `FRS_A_FMAX:  rst_val = `FRS_R_FMAX;
        `FRS_A_FILT:  rst_val = `FRS_R_FILT;
        `FRS_A_X1:    rst_val = `FRS_R_X1;
        `FRS_A_Y1:    rst_val = `FRS_R_Y1;
        `FRS_A_X2:    rst_val = `FRS_R_X2;
        `FRS_A_Y2:    rst_val = `FRS_R_Y2;
        `FRS_A_QUANT: rst_val = `FRS_R_QUANT;
        `FRS_A_CHECK: rst_val = `FRS_R_CHECK;
        default:      rst_val = {DW{1'b0}};
      endcase
    end
  endfunction

  // Indices 0 to 26 are writable settings; 27 to 29 are read-only views
  // assembled in the read mux, so they need no storage here.
  reg  [DW-1:0] regs_q [0:26];
  reg  [1:0]    p_sync_q;
  reg           p_last_q;
  reg  [31:0]   ms_cnt_q;
  reg           tick_q;
  reg  [15:0]   gate_cnt_q;
  reg  [DW-1:0] edge_cnt_q;
  reg  [DW-1:0] mon_q;
  reg  [1:0]    st_q;
  reg  [2:0]    raw_last_q;
  reg  [15:0]   chk_cnt_q;
  reg  [2:0]    step_q;
  wire [DW-1:0] flt;
  integer       i;

  // Terminal decoding: true when any terminal with this function is on.
  function term_on;
    input [5:0] code;
    input [NTERM-1:0] term;
    input [NTERM*6-1:0] fn;
    integer k;
    begin
      term_on = 1'b0;
      for (k = 0; k < NTERM; k = k + 1)
        if (term[k] && fn[k*6 +: 6] == code)
          term_on = 1'b1;
    end
  endfunction

  // Six-bit function code of each terminal, packed for the decoder.
  wire [NTERM*6-1:0] fn_map;
  genvar g;
  generate
    for (g = 0; g < NTERM; g = g + 1) begin : g_fn
      assign fn_map[g*6 +: 6] = regs_q[`FRS_A_TERM1 + g][5:0];
    end
  endgenerate

  // Decoded terminal functions. Terminals sharing a function are ORed,
  // so a duplicate assignment cannot mask an active input.
  wire [2:0] raw_step = {term_on(`FRS_FN_SPD_H, i_terminals, fn_map),
                         term_on(`FRS_FN_SPD_M, i_terminals, fn_map),
                         term_on(`FRS_FN_SPD_L, i_terminals, fn_map)};
  wire hold_on = term_on(`FRS_FN_HOLD, i_terminals, fn_map);
  wire fwd_on  = term_on(`FRS_FN_FWD, i_terminals, fn_map);
  wire rev_on  = term_on(`FRS_FN_REV, i_terminals, fn_map);
  wire [3:0] src = regs_q[`FRS_A_SRC][3:0];
  wire pulse_src = (src == `FRS_SRC_PULSE);
  wire analog = (src == `FRS_SRC_V1) || (src == `FRS_SRC_V2) ||
                (src == `FRS_SRC_I2) || pulse_src;

  // Register writes; index beyond the writable set is ignored.
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      for (i = 0; i < 27; i = i + 1)
        regs_q[i] <= rst_val(i[4:0]);
    end else if (i_wr && i_addr < `FRS_N_RW) begin
      regs_q[i_addr] <= i_wdata;
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always @(posedge i_clk_sys) begin
    if (!i_rstn)
      o_rdata <= {DW{1'b0}};
    else if (!i_rd)
      o_rdata <= {DW{1'b0}};
    else if (i_addr < `FRS_N_RW)
      o_rdata <= regs_q[i_addr];
    else if (i_addr == `FRS_A_MON)
      o_rdata <= mon_q;
    else if (i_addr == `FRS_A_FREQ)
      o_rdata <= o_freq_cmd;
    else if (i_addr == `FRS_A_STAT)
      o_rdata <= {{(DW-7){1'b0}}, hold_on, o_dir_rev, st_q[1], step_q,
                  regs_q[`FRS_A_UNIT][0]};
    else
      o_rdata <= {DW{1'b0}};
  end

  // Millisecond tick from the system clock.
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ms_cnt_q <= 32'h0;
      tick_q   <= 1'b0;
    end else if (ms_cnt_q == MS_CYCLES - 1) begin
      ms_cnt_q <= 32'h0;
      tick_q   <= 1'b1;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
      tick_q   <= 1'b0;
    end
  end

  // Pulse pin synchroniser; edges are seen only past the second stage.
  // The pin is unrelated to the system clock, and the two stages keep a
  // metastable sample away from the edge detector.
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      p_sync_q <= 2'b00;
      p_last_q <= 1'b0;
    end else begin
      p_sync_q <= {p_sync_q[0], i_pulse_in_pin};
      p_last_q <= p_sync_q[1];
    end
  end

  // Rising edges counted over a 100 ms gate give the rate in 0.01 kHz.
  // An edge seen in the gate-end cycle itself is dropped, so a reading
  // may come out one count low.
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      gate_cnt_q <= 16'h0;
      edge_cnt_q <= {DW{1'b0}};
      mon_q      <= {DW{1'b0}};
    end else begin
      if (tick_q && gate_cnt_q == GATE_MS - 1) begin
        gate_cnt_q <= 16'h0;
        edge_cnt_q <= {DW{1'b0}};
        mon_q <= (edge_cnt_q > `FRS_MON_MAX) ? `FRS_MON_MAX
                                             : edge_cnt_q;
      end else begin
        if (tick_q)
          gate_cnt_q <= gate_cnt_q + 16'h1;
        if (p_sync_q[1] && !p_last_q && edge_cnt_q != {DW{1'b1}})
          edge_cnt_q <= edge_cnt_q + 1'b1;
      end
    end
  end

  frs_lpf #(
    .DW (DW)
  ) u_lpf (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_tick    (tick_q),
    .i_x       (mon_q),
    .i_tc      (regs_q[`FRS_A_FILT]),
    .o_y       (flt)
  );

  // Step select settling: restart the wait on every change of inputs.
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_q       <= ST_IDLE;
      raw_last_q <= 3'h0;
      chk_cnt_q  <= 16'h0;
      step_q     <= 3'h0;
    end else if (raw_step != raw_last_q) begin
      raw_last_q <= raw_step;
      chk_cnt_q  <= regs_q[`FRS_A_CHECK] + 16'h1;
      st_q       <= ST_WAIT;
    end else begin
      case (st_q)
        ST_IDLE: begin
          chk_cnt_q <= 16'h0;
        end
        ST_WAIT: begin
          if (chk_cnt_q == 16'h0) begin
            step_q <= raw_last_q;
            st_q   <= ST_IDLE;
          end else if (tick_q) begin
            chk_cnt_q <= chk_cnt_q - 16'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  wire signed [31:0] r_s  = $signed({16'h0000, flt});
  wire signed [31:0] x1_s = $signed({16'h0000, regs_q[`FRS_A_X1]});
  wire signed [31:0] x2_s = $signed({16'h0000, regs_q[`FRS_A_X2]});
  wire signed [31:0] y1_s = $signed({16'h0000, regs_q[`FRS_A_Y1]});
  wire signed [31:0] y2_s = $signed({16'h0000, regs_q[`FRS_A_Y2]});
  wire [31:0] q_u  = {16'h0000, regs_q[`FRS_A_QUANT]};
  wire [31:0] fs_u = {16'h0000, regs_q[`FRS_A_FULL]};
  wire [31:0] fmax = {16'h0000, regs_q[`FRS_A_FMAX]};

  reg signed [31:0] pct_s;
  reg [31:0] pct_u;
  reg [31:0] pulse_f;
  reg [31:0] src_f;
  reg [31:0] sel_f;
  reg [31:0] next_f;
  reg [31:0] disp;

  // Pulse path: line through two points, quantize, scale to full scale.
  // All arithmetic is 32 bits wide; full percent times a 16-bit full-scale
  // value stays inside that width, but the line product of two 16-bit differences can overflow it.
  always @* begin
    if (x2_s <= x1_s || r_s <= x1_s)
      pct_s = y1_s;
    else if (r_s >= x2_s)
      pct_s = y2_s;
    else
      pct_s = y1_s + (r_s - x1_s) * (y2_s - y1_s) / (x2_s - x1_s);
    pct_u = (pct_s < 0) ? 32'h0 : pct_s[31:0];
    if (pct_u > `FRS_PCT_FULL)
      pct_u = `FRS_PCT_FULL;
    if (q_u != 32'h0)
      pct_u = (pct_u / q_u) * q_u;
    pulse_f = pct_u * fs_u / `FRS_PCT_FULL;
  end

  // Source and step selection, hold and clamp to the maximum frequency.
  always @* begin
    case (src)
      `FRS_SRC_PULSE:  src_f = pulse_f;
      `FRS_SRC_SERIAL: src_f = {16'h0000, regs_q[`FRS_A_SERIAL]};
      default:         src_f = {16'h0000, i_ext_freq};
    endcase
    if (step_q == 3'h0)
      sel_f = src_f;
    else
      sel_f = {16'h0000, regs_q[`FRS_A_STEP1 + step_q - 5'h1]};
    if (sel_f > fmax)
      next_f = fmax;
    else
      next_f = sel_f;
    // Hold feeds the registered command back, so the output freezes at
    // exactly the value last sent.
    if (analog && hold_on && step_q == 3'h0)
      next_f = {16'h0000, o_freq_cmd};
    if (regs_q[`FRS_A_UNIT][0])
      disp = next_f * 32'd120 / (32'd100 * POLES);
    else
      disp = next_f;
  end

  // Registered outputs.
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_freq_cmd        <= {DW{1'b0}};
      o_dir_rev         <= 1'b0;
      o_forward_run_cmd <= 1'b0;
      o_step            <= 3'h0;
      o_speed_disp      <= {DW{1'b0}};
    end else begin
      o_freq_cmd        <= next_f[DW-1:0];
      o_dir_rev         <= rev_on ^ (pulse_src &&
                           regs_q[`FRS_A_INV][0]);
      o_forward_run_cmd <= fwd_on;
      o_step            <= step_q;
      o_speed_disp      <= disp[DW-1:0];
    end
  end
endmodule

// ===== test/frs_top_monitor.sv
/*
  Port checker for frs_top: register port timing, reset levels,
  step settling and speed display.
  Assumes it is bound into frs_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module frs_top_monitor #(
  parameter DW        = 16,
  parameter NTERM     = 7,
  parameter MS_CYCLES = 10
) (
  input wire             i_clk_sys,
  input wire             i_rstn,
  input wire [4:0]       i_addr,
  input wire [DW-1:0]    i_wdata,
  input wire             i_wr,
  input wire             i_rd,
  input wire [DW-1:0]    o_rdata,
  input wire [NTERM-1:0] i_terminals,
  input wire [DW-1:0]    o_freq_cmd,
  input wire             o_dir_rev,
  input wire             o_forward_run_cmd,
  input wire [2:0]       o_step,
  input wire [DW-1:0]    o_speed_disp
);
  reg [NTERM-1:0] last_q;
  reg [31:0]      quiet_q;

  // Counts the cycles since the terminals last moved.
  always @(posedge i_clk_sys) begin
    last_q <= i_terminals;
    if (!i_rstn || i_terminals != last_q)
      quiet_q <= 32'h0000_0000;
    else if (quiet_q != 32'hffff_ffff)
      quiet_q <= quiet_q + 32'h0000_0001;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  // A write to a plain register followed by a read of the same index.
  sequence wr_then_rd;
    (i_wr && i_addr >= 5'h03 && i_addr <= 5'h04) ##2
    (i_rd && i_addr == $past(i_addr, 2));
  endsequence

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (i_rd && i_addr > 5'h1d |=> o_rdata == 0)
    else $error("unmapped read returned nonzero");
  write_readback_a: assert property (
    wr_then_rd |=> o_rdata == $past(i_wdata, 3))
    else $error("register did not read back written data");
  reset_quiet_a: assert property (disable iff (1'b0) !i_rstn |=>
    o_freq_cmd == 0 && o_step == 0 && !o_dir_rev && !o_forward_run_cmd)
    else $error("outputs not cleared by reset");
  step_settle_a: assert property (
    $changed(o_step) |-> quiet_q >= MS_CYCLES)
    else $error("step applied before terminals settled");
  monitor_range_a: assert property (
    i_rd && i_addr == 5'h1b |=> o_rdata <= 16'h1388)
    else $error("pulse monitor above its span");
  disp_zero_a: assert property (
    (o_freq_cmd == 0)[*3] |-> o_speed_disp == 0)
    else $error("speed display nonzero at zero command");
  disp_bound_a: assert property (
    $stable(o_freq_cmd)[*3] |-> o_speed_disp <= o_freq_cmd)
    else $error("speed display above the command");
endmodule

bind frs_top frs_top_monitor #(
  .DW        (DW),
  .NTERM     (NTERM),
  .MS_CYCLES (MS_CYCLES)
) chk (
  .i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_terminals, .o_freq_cmd, .o_dir_rev, .o_forward_run_cmd, .o_step,
  .o_speed_disp);

// ===== test/frs_far_side.sv
/*
  Far-side model: a free-running pulse source and the terminal levels.
  Assumes the bench sets the levels; the pulse keeps a fixed phase to the bench clock.
*/
`timescale 1ns/10ps
module frs_far_side #(
  parameter HALF_NS = 10
) (
  input  wire [6:0] i_levels,
  output reg        o_pulse,
  output wire [6:0] o_terminals
);
  // Terminal levels pass straight to the pins.
  assign o_terminals = i_levels;

  // Pulse train with edges kept clear of the clock edges.
  initial begin
    o_pulse = 1'b0;
    #3;
    forever #HALF_NS o_pulse = !o_pulse;
  end
endmodule

// ===== test/frs_top_test.sv
/*
  Testbench for frs_top: register calls with expected values.
  Assumes a 200 MHz clock and shortened millisecond and gate counts.
*/
`timescale 1ns/10ps
module frs_top_test;
  reg         clk;
  reg         rstn;
  reg         wr;
  reg         rd;
  reg  [4:0]  addr;
  reg  [15:0] wdata;
  reg  [15:0] ext;
  reg  [6:0]  lv;
  reg  [15:0] k;
  wire [15:0] rdata;
  wire [15:0] freq;
  wire [15:0] disp;
  wire [6:0]  term;
  wire [2:0]  step;
  wire        pin;
  wire        rev;
  wire        fwd;
  integer     miscompares = 0;
  integer     n_tests = 0;

  frs_top #(.MS_CYCLES(10), .GATE_MS(4)) uut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pulse_in_pin(pin),
    .i_terminals(term), .i_ext_freq(ext), .o_freq_cmd(freq),
    .o_dir_rev(rev), .o_forward_run_cmd(fwd), .o_step(step),
    .o_speed_disp(disp));
  frs_far_side far (.i_levels(lv), .o_pulse(pin), .o_terminals(term));

  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wreg(input [4:0] a, input [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rreg(input [4:0] a, input [15:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task tally_and_finish;
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #100000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end

  // Main sequence: pulse path, serial and keypad sources, steps, hold.
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 5'h00;
    wdata = 16'h0000; ext = 16'h0000; lv = 7'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rreg(5'h04, 16'h0000, "low rate reset");
    rreg(5'h1f, 16'h0000, "unmapped read");
    wreg(5'h00, 16'h000c);
    wreg(5'h06, 16'h000a);
    wreg(5'h09, 16'h0000);
    // Default 10 ms filter: about ten ticks after the first gate the
    // filtered rate stands at 63% of 10, which maps to 36.00 Hz.
    cyc(136);
    chk("filter 63 pct", 16'h0e10, freq);
    wreg(5'h03, 16'h0000);
    rreg(5'h03, 16'h0000, "filter readback");
    rreg(5'h1b, 16'h000a, "pulse monitor");
    cyc(2);
    chk("full rate", 16'h1770, freq);
    wreg(5'h01, 16'h0fa0);
    cyc(8);
    chk("full scale 40", 16'h0fa0, freq);
    wreg(5'h01, 16'h1770);
    wreg(5'h07, 16'h1388);
    cyc(8);
    chk("half pct", 16'h0bb8, freq);
    wreg(5'h07, 16'h2710);
    wreg(5'h06, 16'h001e);
    wreg(5'h09, 16'h03e8);
    cyc(8);
    chk("quantized", 16'h0708, freq);
    wreg(5'h08, 16'h0001);
    cyc(4);
    chk("invert", 16'h0001, {15'h0000, rev});
    wreg(5'h00, 16'h0006);
    wreg(5'h0b, 16'h1b58);
    cyc(4);
    chk("serial clamp", 16'h1770, freq);
    chk("invert off src", 16'h0000, {15'h0000, rev});
    wreg(5'h0b, 16'h04d2);
    cyc(4);
    chk("serial", 16'h04d2, freq);
    @(posedge clk) ext <= 16'h09c4;
    wreg(5'h00, 16'h0000);
    cyc(4);
    chk("step zero", 16'h09c4, freq);
    wreg(5'h14, 16'h0007);
    wreg(5'h15, 16'h0008);
    wreg(5'h16, 16'h0009);
    wreg(5'h17, 16'h0015);
    wreg(5'h1a, 16'h0001);
    wreg(5'h0c, 16'h0002);
    for (k = 16'h0001; k < 16'h0008; k = k + 16'h0001)
      wreg(5'h0c + k[4:0], 16'h0064 * k);
    for (k = 16'h0001; k < 16'h0008; k = k + 16'h0001) begin
      @(posedge clk) lv <= k[6:0];
      cyc(5);
      chk("step early", k - 16'h0001, {13'h0000, step});
      cyc(40);
      chk("step", k, {13'h0000, step});
      chk("step freq", 16'h0064 * k, freq);
    end
    @(posedge clk) lv <= 7'h40;
    cyc(40);
    chk("forward", 16'h0001, {15'h0000, fwd});
    chk("back to step zero", 16'h09c4, freq);
    wreg(5'h00, 16'h0002);
    @(posedge clk) ext <= 16'h07d0;
    cyc(4);
    @(posedge clk) lv <= 7'h48;
    cyc(4);
    @(posedge clk) ext <= 16'h0bb8;
    cyc(4);
    chk("hold", 16'h07d0, freq);
    @(posedge clk) lv <= 7'h40;
    cyc(4);
    chk("hold release", 16'h0bb8, freq);
    wreg(5'h0a, 16'h0001);
    cyc(4);
    chk("rpm", 16'h0384, disp);
    wreg(5'h18, 16'h0002);
    @(posedge clk) lv <= 7'h50;
    cyc(4);
    chk("reverse", 16'h0001, {15'h0000, rev});
    tally_and_finish;
  end
endmodule
